// >>> inc/rail_seq_pkg.sv
// Constants and types for the three rail power sequencer
package rail_seq_pkg;

    localparam int unsigned CNT_W            = 4;
    // First and step delays in ticks; the first delay lands on 9 or 10 by tick phase
    localparam logic [3:0]  FIRST_DELAY_TICKS = 4'h9;
    localparam logic [3:0]  STEP_DELAY_TICKS  = 4'h8;
    localparam logic [3:0]  CNT_RESET         = 4'h0;
    localparam int unsigned RAIL_COUNT        = 3;

    // Sequencer states, Gray coded along power up then power down
    typedef enum logic [2:0] {
        ST_OFF     = 3'b000,
        ST_DELAY1  = 3'b001,
        ST_UP1     = 3'b011,
        ST_UP2     = 3'b010,
        ST_ON      = 3'b110,
        ST_DOWN3   = 3'b111,
        ST_DOWN2   = 3'b101,
        ST_DOWN1   = 3'b100
    } seq_state_t;

    // Three open-drain rail pins
    typedef struct packed {
        logic [2:0] out;
        logic [2:0] oe;
    } rail_pins_t;

endpackage : rail_seq_pkg

// >>> rtl/three_rail_power_sequencer.sv
// Three rail power sequencer: staggered release and reverse-order pull-down of open-drain flags
`timescale 1ns/1ps

// Notes on behaviour
// R1 - After reset all three flags stay deasserted until enable is seen high. With invert high, pins reset low (asserted) until the next enabled clock.
// R2 - First flag releases nine to ten ticks after enable rises.
// R3 - Second flag releases exactly eight ticks after the first.
// R4 - Third flag releases eight ticks after the second.
// R5 - On enable drop after full power up, third flag drops after nine-ten ticks.
// R6 - Then second drops eight ticks after third, first eight after second.
// R7 - Polarity invert high inverts all three flag outputs; low means active high.
// R8 - The system must tie polarity invert to a fixed level, never floating.
// R9 - Enable dropping before the first release resets the count, flags stay off.
// R10 - Enable drop mid power up causes a controlled shutdown, not an abrupt one.
// R11 - Such shutdown drops only released flags, descending, with normal step delays.
// R12 - All delay counting advances only on the single-cycle timing tick.
module three_rail_power_sequencer
(
    // Clock and reset
    input  wire logic                    clk_in,
    input  wire logic                    reset_in,
    input  wire logic                    clk_en_in,
    // Control
    input  wire logic                    enable_in,
    input  wire logic                    flag_polarity_invert_in,
    input  wire logic                    timing_tick_in,
    // Rail flags, open drain
    input  wire logic [2:0]              rail_pins_in,
    output rail_seq_pkg::rail_pins_t     rail_pins_out,
    output logic      [2:0]              rail_release_out
);
    import rail_seq_pkg::*;

    seq_state_t             state_r;
    seq_state_t             state_nxt;
    logic [CNT_W-1:0]       cnt_r;
    logic [CNT_W-1:0]       cnt_nxt;
    logic [2:0]             release_r;
    logic [2:0]             release_nxt;
    wire logic [2:0]        pin_out;
    wire logic [2:0]        pin_oe;

    // Named decodes
    wire logic              tick        = timing_tick_in;                        // R12
    wire logic              en_low      = !enable_in;
    wire logic [CNT_W-1:0]  cnt_inc     = cnt_r + CNT_W'(1);
    wire logic              first_due   = tick && (cnt_inc == FIRST_DELAY_TICKS);
    wire logic              step_due    = tick && (cnt_inc == STEP_DELAY_TICKS);
    wire logic [2:0]        flag_level  = release_r ^ {3{flag_polarity_invert_in}}; // R7

    // Pin read-back is not used: the flag level is fully known from the release state
    // The first delay counts whole ticks after enable; the partial tick before gives the 9 to 10 spread
    always_comb
    begin
        state_nxt   = state_r;
        cnt_nxt     = cnt_r;
        release_nxt = release_r;
        unique case (state_r)
            ST_OFF:
            begin
                cnt_nxt = CNT_RESET;
                if (enable_in)
                begin
                    state_nxt = ST_DELAY1;
                end
            end
            ST_DELAY1:
            begin
                if (en_low)
                begin
                    state_nxt = ST_OFF;                           // R9
                    cnt_nxt   = CNT_RESET;                        // R9
                end
                else if (first_due)
                begin
                    release_nxt = 3'b001;                         // R2
                    state_nxt   = ST_UP1;
                    cnt_nxt     = CNT_RESET;
                end
                else if (tick)                                    // R12
                begin
                    cnt_nxt = cnt_inc;
                end
            end
            ST_UP1:
            begin
                if (en_low)
                begin
                    // Only the first rail is up, so go straight to its drop
                    state_nxt = ST_DOWN1;                         // R10 R11
                    cnt_nxt   = CNT_RESET;
                end
                else if (step_due)
                begin
                    release_nxt = 3'b011;                         // R3
                    state_nxt   = ST_UP2;
                    cnt_nxt     = CNT_RESET;
                end
                else if (tick)                                    // R12
                begin
                    cnt_nxt = cnt_inc;
                end
            end
            ST_UP2:
            begin
                if (en_low)
                begin
                    // Two rails are up: the second one drops first
                    state_nxt = ST_DOWN2;                         // R10 R11
                    cnt_nxt   = CNT_RESET;
                end
                else if (step_due)
                begin
                    release_nxt = 3'b111;                         // R4
                    state_nxt   = ST_ON;
                    cnt_nxt     = CNT_RESET;
                end
                else if (tick)                                    // R12
                begin
                    cnt_nxt = cnt_inc;
                end
            end
            ST_ON:
            begin
                cnt_nxt = CNT_RESET;
                if (en_low)
                begin
                    state_nxt = ST_DOWN3;                         // R5
                end
            end
            ST_DOWN3:
            begin
                if (first_due)
                begin
                    release_nxt = 3'b011;                         // R5
                    state_nxt   = ST_DOWN2;
                    cnt_nxt     = CNT_RESET;
                end
                else if (tick)                                    // R12
                begin
                    cnt_nxt = cnt_inc;
                end
            end
            ST_DOWN2:
            begin
                if (step_due)
                begin
                    release_nxt = 3'b001;                         // R6 R11
                    state_nxt   = ST_DOWN1;
                    cnt_nxt     = CNT_RESET;
                end
                else if (tick)                                    // R12
                begin
                    cnt_nxt = cnt_inc;
                end
            end
            ST_DOWN1:
            begin
                if (step_due)
                begin
                    release_nxt = 3'b000;                         // R6 R11
                    state_nxt   = ST_OFF;
                    cnt_nxt     = CNT_RESET;
                end
                else if (tick)                                    // R12
                begin
                    cnt_nxt = cnt_inc;
                end
            end
        endcase
    end

    // Power down runs to completion even if enable returns, so no rail is half cycled
    always_ff @(posedge clk_in)
    begin
        if (reset_in)
        begin
            state_r   <= ST_OFF;                                  // R1
            cnt_r     <= CNT_RESET;
            release_r <= 3'b000;                                  // R1
        end
        else if (clk_en_in)
        begin
            state_r   <= state_nxt;
            cnt_r     <= cnt_nxt;
            release_r <= release_nxt;
        end
    end

    // One open-drain pull-down per rail; oe high pulls the pin low
    genvar rail;
    generate
        for (rail = 0; rail < RAIL_COUNT; rail++)
        begin : g_rail
            logic out_r;
            logic oe_r;

            always_ff @(posedge clk_in)
            begin
                if (reset_in)
                begin
                    out_r <= 1'b0;
                    oe_r  <= 1'b1;                                // R1
                end
                else if (clk_en_in)
                begin
                    out_r <= 1'b0;
                    oe_r  <= ~flag_level[rail];                   // R7
                end
            end

            assign pin_out[rail] = out_r;
            assign pin_oe[rail]  = oe_r;
        end
    endgenerate

    assign rail_pins_out    = {pin_out, pin_oe};
    assign rail_release_out = release_r;

endmodule : three_rail_power_sequencer

// >>> test/three_rail_power_sequencer_checker.sv
// Port checks for the rail sequencer
`timescale 1ns/1ps
module seq_checker
(
    // Design ports
    input wire logic       clk_in,
    input wire logic       reset_in,
    input wire logic       clk_en_in,
    input wire logic       enable_in,
    input wire logic       flag_polarity_invert_in,
    input wire logic       timing_tick_in,
    input wire rail_seq_pkg::rail_pins_t rail_pins_out,
    input wire logic [2:0] rail_release_out
);
    import rail_seq_pkg::*;
    logic [2:0] rel_r;
    logic       en_r;
    logic [7:0] tk_r;
    logic [7:0] cnt_r;
    wire        chg = rail_release_out != rel_r;
    // Ticks since the last flag change and since the last enable edge
    always_ff @(posedge clk_in)
    begin
        rel_r <= rail_release_out;
        en_r <= enable_in;
        tk_r <= (chg ? 8'h00 : tk_r) + 8'(timing_tick_in);
        cnt_r <= (enable_in != en_r ? 8'h00 : cnt_r) + 8'(timing_tick_in);
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence full_drop;
        chg && rel_r == 3'h7;
    endsequence
    freeze_hold_a: assert property (!clk_en_in |=> $stable(rail_release_out) && $stable(rail_pins_out))
        else $error("moved while frozen");
    pins_sense_a: assert property (!$past(reset_in) && $past(clk_en_in) |-> rail_pins_out.out == 3'h0 &&
        rail_pins_out.oe == ~($past(rail_release_out) ^ {3{$past(flag_polarity_invert_in)}})) else $error("pin sense");
    stay_off_a: assert property (!enable_in && rail_release_out == 3'h0 |=> rail_release_out == 3'h0)
        else $error("released while disabled");
    legal_order_a: assert property (rail_release_out inside {3'h0, 3'h1, 3'h3, 3'h7})
        else $error("flag order");
    first_rel_a: assert property (chg && rel_r == 3'h0 |-> cnt_r inside {8'h09, 8'h0A})
        else $error("first delay");
    up_step_a: assert property (chg && rail_release_out > rel_r && rel_r != 3'h0 |-> tk_r == 8'h08)
        else $error("up step");
    down_first_a: assert property (full_drop |-> rail_release_out == 3'h3 && cnt_r inside {8'h09, 8'h0A})
        else $error("down start");
    down_step_a: assert property (chg && rail_release_out < rel_r && rel_r != 3'h7 |->
        tk_r == 8'h08 || cnt_r inside {8'h08, 8'h09}) else $error("down step");
    tick_only_a: assert property (chg |-> $past(timing_tick_in))
        else $error("moved without tick");
endmodule : seq_checker
bind three_rail_power_sequencer seq_checker chk (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en_in),
    .enable_in(enable_in),
    .flag_polarity_invert_in(flag_polarity_invert_in), .timing_tick_in(timing_tick_in),
    .rail_pins_out(rail_pins_out), .rail_release_out(rail_release_out));

// >>> test/rail_pullup_model.sv
// Regulator enable pins with pull-ups on the flag lines
`timescale 1ns/1ps
module rail_pullup_model
(
    // Drive and level
    input  wire logic [2:0] pull_low_in,
    output logic      [2:0] level_out
);
    // A released flag floats up to the pull-up
    assign level_out = ~pull_low_in;
endmodule : rail_pullup_model

// >>> test/three_rail_power_sequencer_tb.sv
// Self-checking bench for the rail sequencer
`timescale 1ns/1ps
`define CHK(g, e) n_compared++; if ((g) !== (e)) begin num_errors++; $display("MISMATCH %0t got %h exp %h", $time, g, e); end
module three_rail_power_sequencer_tb;
    import rail_seq_pkg::*;
    logic       clk_in = 0, reset_in = 1, enable_in = 0, flag_polarity_invert = 0, tick = 0, clk_en = 1;
    logic [2:0] level, rel;
    rail_pins_t pins;
    int         num_errors = 0, n_compared = 0, seed = 32'hdc2e, tcnt = 0, gap = 0;
    three_rail_power_sequencer dut (.clk_in(clk_in), .reset_in(reset_in), .clk_en_in(clk_en), .enable_in(enable_in),
        .flag_polarity_invert_in(flag_polarity_invert), .timing_tick_in(tick), .rail_pins_in(level), .rail_pins_out(pins),
        .rail_release_out(rel));
    rail_pullup_model far (.pull_low_in(pins.oe), .level_out(level));
    initial forever #10 clk_in = ~clk_in;
    // Ticks at least four edges apart, so one tick at most lands near an enable edge
    always @(posedge clk_in)
    begin
        if (gap == 0) gap = 3 + {$random(seed)} % 3; else gap--;
        tick <= (gap == 0);
        // Freeze single non-tick edges only, so no tick is lost and pins settle within two edges
        clk_en <= (gap == 0) || !clk_en || ({$random(seed)} % 8 != 0);
        tcnt <= tcnt + tick;
    end
    function automatic logic [2:0] pin_level(input logic [2:0] r, input logic i);
        return r ^ {3{i}};
    endfunction : pin_level
    task automatic wait_rel(input logic [2:0] v);
        for (int k = 0; k < 600 && rel !== v; k++) @(negedge clk_in);
        `CHK(rel, v)
        repeat (2) @(negedge clk_in);
        `CHK(level, pin_level(v, flag_polarity_invert))
    endtask : wait_rel
    task automatic report_and_stop;
        if (num_errors == 0 && n_compared > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : report_and_stop
    initial
    begin
        int t0;
        for (int k = 0; k < 4; k++)
        begin
            @(posedge clk_in) reset_in <= 1;
            flag_polarity_invert <= k[0];
            repeat (2) @(posedge clk_in);
            reset_in <= 0;
            repeat (3) @(negedge clk_in);
            `CHK(level, pin_level(3'h0, flag_polarity_invert))
            // Short enable pulse ends before any flag can release
            @(posedge clk_in) enable_in <= 1;
            repeat (4 + {$random(seed)} % 20) @(posedge clk_in);
            enable_in <= 0;
            repeat (40) @(negedge clk_in);
            `CHK(rel, 3'h0)
            @(posedge clk_in) enable_in <= 1;
            t0 = tcnt;
            wait_rel(3'h7);
            `CHK((tcnt - t0) inside {[25:27]}, 1'b1)
            @(posedge clk_in) enable_in <= 0;
            wait_rel(3'h3);
            wait_rel(3'h0);
            // Drop enable partway through power up
            @(posedge clk_in) enable_in <= 1;
            wait_rel(k[1] ? 3'h3 : 3'h1);
            @(posedge clk_in) enable_in <= 0;
            wait_rel(3'h0);
        end
        report_and_stop();
    end
    initial
    begin
        #400000;
        num_errors++;
        report_and_stop();
    end
endmodule : three_rail_power_sequencer_tb
